// *** rtl/emp_pkg.sv ***
// shared constants and types for the dual-role external nibble port
// How it works
// - flow control strap: 1 on, 0 off
// - role strap: 1 MAC role, 0 PHY role
// - role strap touches only this port
// - serial management writes configure transceiver, switch
// - port works only with enable strap high
// - pin roles apply only with nibble signalling
// - PHY role drives tx clock, captures on rise
// - PHY role collision only in half duplex
// - PHY role rx valid changes on falling edge
// - PHY role rx nibble launched on falling edge
// - PHY role never clocks the rx clock pin
// - MAC role tx nibble changes on rising edge
// - MAC role tx valid launched on rising edge
// - MAC role captures rx nibble on rx rise
// - enable strap low means plain switch, default
// - serial variant never combined with MAC role
package emp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MII_CLK_PERIOD_NS = 40;
  localparam int MII_HALF_CYC = MII_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [2:0] MII_DIV_LAST = 3'(2 * MII_HALF_CYC - 1);
  localparam logic [2:0] MII_DIV_FALL = 3'(MII_HALF_CYC);
  // strap default levels; no flop loads them, the straps are only captured from the pins
  localparam logic FLOW_CTRL_RST = 1'b1;
  localparam logic ROLE_RST = 1'b0;
  localparam logic EXT_EN_RST = 1'b0;
  localparam logic SNI_RST = 1'b0;
  localparam logic ROLE_MAC = 1'b1;
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 32;
  // management frame fields
  localparam logic [2:0] SMI_START_SEEN = 3'h5;
  localparam logic [1:0] SMI_OP_RD = 2'h2;
  localparam logic [1:0] SMI_OP_WR = 2'h1;
  localparam logic [4:0] SMI_HDR_LAST = 5'hB;
  localparam logic [4:0] SMI_DATA_LAST = 5'hF;
  typedef struct packed {
    logic valid;
    logic [NIB_W-1:0] data;
  } emp_nib_t;
  typedef struct packed {
    logic [4:0] phy;
    logic [4:0] regad;
    logic [15:0] data;
  } emp_mgmt_t;
endpackage : emp_pkg

// *** rtl/emp_port.sv ***
// external nibble port: egress fifo, role muxing, clocking and management slave
`timescale 1ns/100ps
module emp_fifo #(
  parameter int W = 5,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  // extra pointer bit tells full from empty
  assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = wr_q != rd_q;
  // head word read straight from the array, so data stands with out_valid
  assign out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : emp_fifo

module emp_port (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // strap pins, captured while reset is held
  input wire logic ext_port_flow_ctrl_enable,
  input wire logic port_role_select,
  input wire logic external_port_enable,
  input wire logic serial_nibble_select,
  // tx clock pin
  input wire logic ext_port_tx_clock_i,
  output logic ext_port_tx_clock_o,
  output logic ext_port_tx_clock_oe,
  // tx nibble and frame valid pins
  input wire logic [3:0] ext_port_tx_nibble_i,
  output logic [3:0] ext_port_tx_nibble_o,
  output logic ext_port_tx_nibble_oe,
  input wire logic ext_port_tx_frame_valid_i,
  output logic ext_port_tx_frame_valid_o,
  output logic ext_port_tx_frame_valid_oe,
  // collision pin
  input wire logic ext_port_collision_i,
  output logic ext_port_collision_o,
  output logic ext_port_collision_oe,
  // rx nibble, frame valid and clock pins
  input wire logic [3:0] ext_port_rx_nibble_i,
  output logic [3:0] ext_port_rx_nibble_o,
  output logic ext_port_rx_nibble_oe,
  input wire logic ext_port_rx_frame_valid_i,
  output logic ext_port_rx_frame_valid_o,
  output logic ext_port_rx_frame_valid_oe,
  input wire logic ext_port_rx_clock_i,
  output logic ext_port_rx_clock_o,
  output logic ext_port_rx_clock_oe,
  // management serial pins
  input wire logic mgmt_clock_i,
  input wire logic mgmt_data_i,
  output logic mgmt_data_o,
  output logic mgmt_data_oe,
  // switch side: nibbles towards the link
  input wire logic sw_out_valid,
  output logic sw_out_ready,
  input wire logic [3:0] sw_out_nibble,
  // switch side: nibbles from the link
  output emp_pkg::emp_nib_t sw_in_word,
  output logic sw_in_stb,
  // switch side: port status and settings
  input wire logic sw_half_duplex,
  input wire logic sw_collision,
  output logic sw_partner_collision,
  output logic flow_ctrl_en,
  output logic port_active,
  output logic role_is_mac,
  // switch side: management access
  output emp_pkg::emp_mgmt_t mgmt_word,
  output logic mgmt_wr,
  output logic mgmt_rd_req,
  input wire logic [15:0] mgmt_rd_data
);
  typedef enum {SMI_IDLE, SMI_HDR, SMI_TA, SMI_DATA} emp_smi_t;
  // pins from outside: two flops each, a third for edges
  // bit map: 14 tx clock, 13 rx clock, 12 mgmt clock, 11 mgmt data,
  // 10:6 tx valid and nibble, 5:1 rx valid and nibble, 0 collision
  logic [14:0] pin_s1_q;
  logic [14:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [3:0] strap_s1_q;
  logic [3:0] strap_s2_q;
  logic flow_q;
  logic role_q;
  logic ext_en_q;
  logic sni_q;
  logic active;
  logic mac;
  // nibble-rate divider and the edge pulses: PHY ones from the divider, MAC ones from the pins
  logic [2:0] div_q;
  logic gen_clk_q;
  logic phy_rise;
  logic phy_fall;
  logic mac_tx_rise;
  logic mac_rx_rise;
  logic egress_evt;
  logic eg_valid;
  logic [3:0] eg_data;
  logic mdc_rise;
  logic mdio_s;
  emp_smi_t smi_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic [15:0] rd_sh_q;
  logic rd_q;
  // only the second and third stages feed logic; the first may still be settling
  always_ff @(posedge clock) begin
    pin_s1_q <= {ext_port_tx_clock_i, ext_port_rx_clock_i, mgmt_clock_i, mgmt_data_i,
                 ext_port_tx_frame_valid_i, ext_port_tx_nibble_i,
                 ext_port_rx_frame_valid_i, ext_port_rx_nibble_i, ext_port_collision_i};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q[14:12];
    strap_s1_q <= {ext_port_flow_ctrl_enable, port_role_select, external_port_enable,
                   serial_nibble_select};
    strap_s2_q <= strap_s1_q;
  end
  // straps follow the pins while reset is low and freeze at release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flow_q <= strap_s2_q[3];
      role_q <= strap_s2_q[2];
      ext_en_q <= strap_s2_q[1];
      sni_q <= strap_s2_q[0];
    end
  end
  // serial variant and disabled port leave all link pins undriven
  // flow control is only reported upward; pause handling is the switch's job
  assign active = ext_en_q && !sni_q;
  assign mac = role_q == emp_pkg::ROLE_MAC;
  assign flow_ctrl_en = flow_q;
  assign port_active = active;
  assign role_is_mac = mac;
  // PHY role clock: divide the core clock down to the nibble rate
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_q <= '0;
      // high at count 0, so the first pin edge after reset is a full-width rise
      gen_clk_q <= 1'b1;
    end else begin
      div_q <= (div_q == emp_pkg::MII_DIV_LAST) ? '0 : div_q + 1'b1;
      gen_clk_q <= (div_q == emp_pkg::MII_DIV_LAST) ||
                   ((div_q < emp_pkg::MII_DIV_FALL - 1'b1) && gen_clk_q);
    end
  end
  // the pin clock trails the count by one flop: it rises as the count leaves 0
  // and falls as it leaves MII_DIV_FALL, so egress launches in that same edge;
  // capture comes one edge after the rise, once the synchroniser holds the nibble
  assign phy_rise = active && !mac && div_q == emp_pkg::MII_DIV_FALL - 1'b1;
  assign phy_fall = active && !mac && div_q == emp_pkg::MII_DIV_FALL;
  // partner clocks arrive late by the synchroniser, fine at nibble rates
  assign mac_tx_rise = active && mac && pin_s2_q[14] && !pin_s3_q[2];
  assign mac_rx_rise = active && mac && pin_s2_q[13] && !pin_s3_q[1];
  assign egress_evt = phy_fall || mac_tx_rise;
  // egress buffer: drains one nibble per link clock, at its launch edge, fills from the switch
  emp_fifo #(.W(emp_pkg::NIB_W), .DEPTH(emp_pkg::FIFO_DEPTH)) u_egress (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(sw_out_valid),
    .in_ready(sw_out_ready),
    .in_data(sw_out_nibble),
    .out_valid(eg_valid),
    .out_ready(egress_evt),
    .out_data(eg_data)
  );
  // pin directions follow role; rx clock is never driven
  // enables stay low through reset, so nothing fights the partner while straps settle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_port_tx_clock_oe <= 1'b0;
      ext_port_tx_nibble_oe <= 1'b0;
      ext_port_tx_frame_valid_oe <= 1'b0;
      ext_port_collision_oe <= 1'b0;
      ext_port_rx_nibble_oe <= 1'b0;
      ext_port_rx_frame_valid_oe <= 1'b0;
    end else begin
      ext_port_tx_clock_oe <= active && !mac;
      ext_port_tx_nibble_oe <= active && mac;
      ext_port_tx_frame_valid_oe <= active && mac;
      ext_port_collision_oe <= active && !mac;
      ext_port_rx_nibble_oe <= active && !mac;
      ext_port_rx_frame_valid_oe <= active && !mac;
    end
  end
  // in PHY role the tx clock times both directions; in MAC role the partner owns it
  assign ext_port_rx_clock_o = 1'b0;
  assign ext_port_rx_clock_oe = 1'b0;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_port_tx_clock_o <= 1'b0;
    end else begin
      ext_port_tx_clock_o <= gen_clk_q && active && !mac;
    end
  end
  // egress launch: falling edge in PHY role, rising edge in MAC role
  // an empty fifo at a launch edge drops frame valid: the switch must stay ahead
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_port_rx_nibble_o <= '0;
      ext_port_rx_frame_valid_o <= 1'b0;
      ext_port_tx_nibble_o <= '0;
      ext_port_tx_frame_valid_o <= 1'b0;
    end else if (!active) begin
      ext_port_rx_nibble_o <= '0;
      ext_port_rx_frame_valid_o <= 1'b0;
      ext_port_tx_nibble_o <= '0;
      ext_port_tx_frame_valid_o <= 1'b0;
    end else if (phy_fall) begin
      ext_port_rx_nibble_o <= eg_valid ? eg_data : '0;
      ext_port_rx_frame_valid_o <= eg_valid;
    end else if (mac_tx_rise) begin
      ext_port_tx_nibble_o <= eg_valid ? eg_data : '0;
      ext_port_tx_frame_valid_o <= eg_valid;
    end
  end
  // ingress capture: tx pins on our rise, rx pins on partner's rise
  // the strobe fires every link clock; frame valid travels inside the word
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sw_in_word <= '0;
      sw_in_stb <= 1'b0;
    end else begin
      sw_in_stb <= phy_rise || mac_rx_rise;
      if (phy_rise) begin
        sw_in_word <= pin_s2_q[10:6];
      end else if (mac_rx_rise) begin
        sw_in_word <= pin_s2_q[5:1];
      end
    end
  end
  // collision: out in half duplex PHY role, in from the partner in MAC role
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_port_collision_o <= 1'b0;
      sw_partner_collision <= 1'b0;
    end else begin
      ext_port_collision_o <= active && !mac && sw_half_duplex && sw_collision;
      sw_partner_collision <= active && mac && pin_s2_q[0];
    end
  end
  // management slave: preamble, 01 start, op, phy, register, turnaround, data
  // only three bits mark a start, so a frame must follow a quiet or preamble line
  assign mdc_rise = pin_s2_q[12] && !pin_s3_q[0];
  assign mdio_s = pin_s2_q[11];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      smi_q <= SMI_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      rd_q <= 1'b0;
      mgmt_word <= '0;
      mgmt_wr <= 1'b0;
      mgmt_data_o <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end else begin
      mgmt_wr <= 1'b0;
      if (mdc_rise) begin
        sh_q <= {sh_q[14:0], mdio_s};
        cnt_q <= cnt_q + 1'b1;
        case (smi_q)
          SMI_IDLE: begin
            mgmt_data_oe <= 1'b0;
            cnt_q <= '0;
            if ({sh_q[1:0], mdio_s} == emp_pkg::SMI_START_SEEN) smi_q <= SMI_HDR;
          end
          SMI_HDR: begin
            if (cnt_q == emp_pkg::SMI_HDR_LAST) begin
              rd_q <= sh_q[10:9] == emp_pkg::SMI_OP_RD;
              mgmt_word.phy <= sh_q[8:4];
              mgmt_word.regad <= {sh_q[3:0], mdio_s};
              cnt_q <= '0;
              smi_q <= (sh_q[10:9] == emp_pkg::SMI_OP_RD ||
                        sh_q[10:9] == emp_pkg::SMI_OP_WR) ? SMI_TA : SMI_IDLE;
            end
          end
          SMI_TA: begin
            if (cnt_q == '0) begin
              mgmt_data_oe <= rd_q;
              mgmt_data_o <= 1'b0;
            end else begin
              mgmt_data_o <= rd_sh_q[15];
              cnt_q <= '0;
              smi_q <= SMI_DATA;
            end
          end
          SMI_DATA: begin
            mgmt_data_o <= rd_sh_q[15];
            if (cnt_q == emp_pkg::SMI_DATA_LAST) begin
              mgmt_data_oe <= 1'b0;
              mgmt_wr <= !rd_q;
              if (!rd_q) mgmt_word.data <= {sh_q[14:0], mdio_s};
              smi_q <= SMI_IDLE;
            end
          end
          default: smi_q <= SMI_IDLE;
        endcase
      end
    end
  end
  // read data is asked for once the address has settled
  // the answer must stand on mgmt_rd_data in the cycle mgmt_rd_req is high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mgmt_rd_req <= 1'b0;
      rd_sh_q <= '0;
    end else begin
      mgmt_rd_req <= mdc_rise && smi_q == SMI_HDR && cnt_q == emp_pkg::SMI_HDR_LAST &&
                     sh_q[10:9] == emp_pkg::SMI_OP_RD;
      if (mgmt_rd_req) begin
        rd_sh_q <= mgmt_rd_data;
      end else if (mdc_rise && (smi_q == SMI_DATA || (smi_q == SMI_TA && cnt_q != '0))) begin
        rd_sh_q <= {rd_sh_q[14:0], 1'b0};
      end
    end
  end
endmodule : emp_port

// *** verification/emp_port_assertions.sv ***
// pin-level checks for the external nibble port, bound to its top module
`timescale 1ns/100ps
module emp_port_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link pins
  input wire logic ext_port_tx_clock_o,
  input wire logic ext_port_tx_clock_oe,
  input wire logic ext_port_tx_nibble_oe,
  input wire logic ext_port_tx_frame_valid_oe,
  input wire logic ext_port_collision_o,
  input wire logic ext_port_collision_oe,
  input wire logic [3:0] ext_port_rx_nibble_o,
  input wire logic ext_port_rx_nibble_oe,
  input wire logic ext_port_rx_frame_valid_o,
  input wire logic ext_port_rx_frame_valid_oe,
  input wire logic ext_port_rx_clock_o,
  input wire logic ext_port_rx_clock_oe,
  // switch side
  input wire logic sw_half_duplex,
  input wire logic sw_collision,
  input wire logic sw_in_stb,
  input wire logic flow_ctrl_en,
  input wire logic port_active,
  input wire logic role_is_mac
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic s1_q;
  logic s2_q;
  logic phy;
  // outputs only settle two edges after release, so checks wait for that
  always_ff @(posedge clock) begin
    s1_q <= rst_n;
    s2_q <= s1_q & rst_n;
  end
  assign phy = s2_q && port_active && !role_is_mac;
  property p_rxclk_quiet;
    !ext_port_rx_clock_oe && !ext_port_rx_clock_o;
  endproperty
  a_rxclk_quiet: assert property (p_rxclk_quiet) else $error("rx clock pin driven");
  property p_idle;
    s2_q && !port_active |-> !(ext_port_tx_clock_oe || ext_port_tx_nibble_oe || ext_port_rx_nibble_oe
      || ext_port_collision_oe || ext_port_rx_frame_valid_oe || sw_in_stb);
  endproperty
  a_idle: assert property (p_idle) else $error("idle port drives pins");
  property p_phy_dirs;
    phy |-> ext_port_tx_clock_oe && ext_port_collision_oe && ext_port_rx_nibble_oe
      && ext_port_rx_frame_valid_oe && !ext_port_tx_nibble_oe;
  endproperty
  a_phy_dirs: assert property (p_phy_dirs) else $error("phy role directions wrong");
  property p_mac_dirs;
    s2_q && port_active && role_is_mac |-> ext_port_tx_nibble_oe && ext_port_tx_frame_valid_oe
      && !ext_port_tx_clock_oe && !ext_port_collision_oe && !ext_port_rx_nibble_oe;
  endproperty
  a_mac_dirs: assert property (p_mac_dirs) else $error("mac role directions wrong");
  property p_txclk_div;
    phy && $rose(ext_port_tx_clock_o) |-> ##1 ext_port_tx_clock_o ##1 !ext_port_tx_clock_o
      ##1 !ext_port_tx_clock_o ##1 ext_port_tx_clock_o;
  endproperty
  a_txclk_div: assert property (p_txclk_div) else $error("tx clock not 2 high 2 low");
  property p_rx_on_fall;
    phy && ($changed(ext_port_rx_nibble_o) || $changed(ext_port_rx_frame_valid_o))
      |-> $fell(ext_port_tx_clock_o);
  endproperty
  a_rx_on_fall: assert property (p_rx_on_fall) else $error("rx pins off falling edge");
  property p_col;
    phy && ext_port_collision_o |-> $past(sw_half_duplex) && $past(sw_collision);
  endproperty
  a_col: assert property (p_col) else $error("collision without half duplex");
  property p_stb_phy;
    phy && sw_in_stb |-> ($past(ext_port_tx_clock_o) && !$past(ext_port_tx_clock_o, 2))
      || ($past(ext_port_tx_clock_o, 2) && !$past(ext_port_tx_clock_o, 3));
  endproperty
  a_stb_phy: assert property (p_stb_phy) else $error("ingress strobe off tx rise");
  property p_straps_hold;
    s2_q |-> $stable(flow_ctrl_en) && $stable(role_is_mac) && $stable(port_active);
  endproperty
  a_straps_hold: assert property (p_straps_hold) else $error("strap level moved");
endmodule : emp_port_checker

bind emp_port emp_port_checker emp_port_checker_inst (.clock, .rst_n, .ext_port_tx_clock_o,
  .ext_port_tx_clock_oe, .ext_port_tx_nibble_oe, .ext_port_tx_frame_valid_oe, .ext_port_collision_o,
  .ext_port_collision_oe, .ext_port_rx_nibble_o, .ext_port_rx_nibble_oe, .ext_port_rx_frame_valid_o,
  .ext_port_rx_frame_valid_oe, .ext_port_rx_clock_o, .ext_port_rx_clock_oe, .sw_half_duplex,
  .sw_collision, .sw_in_stb, .flow_ctrl_en, .port_active, .role_is_mac);

// *** verification/emp_link_partner.sv ***
// link partner: external mac in phy role, external phy in mac role
`timescale 1ns/100ps
module emp_link_partner (
  // role and pin clock
  input wire logic mac_role,
  input wire logic link_clk,
  output logic src_clk,
  // nibbles towards the device
  output logic [3:0] snd_nib,
  output logic snd_val,
  // nibbles from the device
  input wire logic [3:0] tk_nib,
  input wire logic tk_val
);
  logic [3:0] got[$];
  // free-running mii clock, used by the device only in mac role
  initial begin
    src_clk = 1'b0;
    snd_nib = 4'h0;
    snd_val = 1'b0;
    forever #80 src_clk = ~src_clk;
  end
  // launch on falling edges so the device sees stable data at the rise
  task send_frame(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge link_clk);
      snd_nib <= 4'(k) ^ 4'hA;
      snd_val <= 1'b1;
    end
    @(negedge link_clk);
    snd_val <= 1'b0;
    snd_nib <= ~snd_nib; // idle lines show the inverse, not a stale nibble
  endtask : send_frame
  // mac-role data leaves the device after the rise, so take it at the fall
  always @(posedge link_clk) if (!mac_role && tk_val) got.push_back(tk_nib);
  always @(negedge link_clk) if (mac_role && tk_val) got.push_back(tk_nib);
endmodule : emp_link_partner

// *** verification/tb_top.sv ***
// self-checking bench for the external nibble port in both roles
`timescale 1ns/100ps
module tb_top;
  logic clock, rst_n, flow_s, role_s, ext_s, sni_s, mclk, mdio_drv, col_drv;
  logic sw_out_valid, sw_out_ready, sw_half_duplex, sw_collision, sw_in_stb, sw_partner_collision;
  logic flow_ctrl_en, port_active, role_is_mac, mgmt_data_o, mgmt_data_oe, src_clk, snd_val;
  logic ext_port_tx_clock_o, ext_port_tx_clock_oe, ext_port_tx_nibble_oe;
  logic ext_port_tx_frame_valid_o, ext_port_tx_frame_valid_oe, ext_port_collision_o;
  logic ext_port_collision_oe, ext_port_rx_nibble_oe, ext_port_rx_frame_valid_o;
  logic ext_port_rx_frame_valid_oe, ext_port_rx_clock_o, ext_port_rx_clock_oe;
  logic tx_clk_p, tx_val_p, rx_val_p, rx_clk_p, col_p, mdio_p;
  logic [3:0] sw_out_nibble, ext_port_tx_nibble_o, ext_port_rx_nibble_o, snd_nib, tx_nib_p, rx_nib_p;
  logic [3:0] inq[$];
  emp_pkg::emp_nib_t sw_in_word;
  emp_pkg::emp_mgmt_t mgmt_word;
  int checks = 0;
  int miscompares = 0;
  int wr_n = 0;
  int rq_n = 0;
  logic mgmt_wr, mgmt_rd_req;
  int cyc = 0;
  // wire levels: device when enabled, else partner; collision falls back to col_drv from the bench
  assign tx_clk_p = ext_port_tx_clock_oe ? ext_port_tx_clock_o : src_clk;
  assign tx_nib_p = ext_port_tx_nibble_oe ? ext_port_tx_nibble_o : snd_nib;
  assign tx_val_p = ext_port_tx_frame_valid_oe ? ext_port_tx_frame_valid_o : snd_val;
  assign rx_nib_p = ext_port_rx_nibble_oe ? ext_port_rx_nibble_o : snd_nib;
  assign rx_val_p = ext_port_rx_frame_valid_oe ? ext_port_rx_frame_valid_o : snd_val;
  assign rx_clk_p = ext_port_rx_clock_oe ? ext_port_rx_clock_o : src_clk;
  assign col_p = ext_port_collision_oe ? ext_port_collision_o : col_drv;
  assign mdio_p = mgmt_data_oe ? mgmt_data_o : mdio_drv;
  emp_port emp_port_inst (.clock, .rst_n, .ext_port_flow_ctrl_enable(flow_s),
    .port_role_select(role_s), .external_port_enable(ext_s), .serial_nibble_select(sni_s),
    .ext_port_tx_clock_i(tx_clk_p), .ext_port_tx_clock_o, .ext_port_tx_clock_oe,
    .ext_port_tx_nibble_i(tx_nib_p), .ext_port_tx_nibble_o, .ext_port_tx_nibble_oe,
    .ext_port_tx_frame_valid_i(tx_val_p), .ext_port_tx_frame_valid_o, .ext_port_tx_frame_valid_oe,
    .ext_port_collision_i(col_p), .ext_port_collision_o, .ext_port_collision_oe,
    .ext_port_rx_nibble_i(rx_nib_p), .ext_port_rx_nibble_o, .ext_port_rx_nibble_oe,
    .ext_port_rx_frame_valid_i(rx_val_p), .ext_port_rx_frame_valid_o, .ext_port_rx_frame_valid_oe,
    .ext_port_rx_clock_i(rx_clk_p), .ext_port_rx_clock_o, .ext_port_rx_clock_oe,
    .mgmt_clock_i(mclk), .mgmt_data_i(mdio_p), .mgmt_data_o, .mgmt_data_oe, .sw_out_valid,
    .sw_out_ready, .sw_out_nibble, .sw_in_word, .sw_in_stb, .sw_half_duplex, .sw_collision,
    .sw_partner_collision, .flow_ctrl_en, .port_active, .role_is_mac, .mgmt_word, .mgmt_wr,
    .mgmt_rd_req, .mgmt_rd_data(16'hC3A5));
  emp_link_partner emp_link_partner_inst (.mac_role(role_s), .link_clk(tx_clk_p), .src_clk,
    .snd_nib, .snd_val, .tk_nib(role_s ? tx_nib_p : rx_nib_p), .tk_val(role_s ? tx_val_p : rx_val_p));
  // core clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // collect nibbles the port hands to the switch inside frames
  always @(posedge clock) if (sw_in_stb === 1'b1 && sw_in_word.valid === 1'b1) inq.push_back(sw_in_word.data);
  // count management pulses so each frame can be checked for exactly one
  always @(posedge clock) begin
    if (mgmt_wr === 1'b1) wr_n++;
    if (mgmt_rd_req === 1'b1) rq_n++;
  end
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      final_report();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // straps are only captured while reset is held
  task strap(input logic f, input logic r, input logic e, input logic s);
    @(negedge clock);
    rst_n = 1'b0;
    {flow_s, role_s, ext_s, sni_s} = {f, r, e, s};
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    inq.delete();
    emp_link_partner_inst.got.delete();
    repeat (4) @(negedge clock);
    chk(16'(flow_ctrl_en), 16'(f));
    chk(16'(role_is_mac), 16'(r));
    chk(16'(port_active), 16'(e & ~s));
  endtask : strap
  task push(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clock);
      sw_out_valid = 1'b1;
      sw_out_nibble = 4'(k) ^ 4'h5;
      while (sw_out_ready !== 1'b1) @(negedge clock);
    end
    @(negedge clock);
    sw_out_valid = 1'b0;
  endtask : push
  task egress(input int n);
    push(n);
    for (int t = 0; t < 1000 && emp_link_partner_inst.got.size() < n; t++) @(negedge clock);
    chk(16'(emp_link_partner_inst.got.size()), 16'(n));
    foreach (emp_link_partner_inst.got[k]) chk(16'(emp_link_partner_inst.got[k]), 16'(4'(k) ^ 4'h5));
  endtask : egress
  task ingress(input int n);
    emp_link_partner_inst.send_frame(n);
    repeat (30) @(negedge clock);
    chk(16'(inq.size()), 16'(n));
    foreach (inq[k]) chk(16'(inq[k]), 16'(4'(k) ^ 4'hA));
  endtask : ingress
  // one management clock period of 16 core cycles, data set while low
  task mbit(input logic b, output logic s);
    mdio_drv = b;
    repeat (8) @(negedge clock);
    s = mdio_p;
    mclk = 1'b1;
    repeat (8) @(negedge clock);
    mclk = 1'b0;
  endtask : mbit
  // one management frame: a read checks the returned word, a write the word handed on
  task mxfer(input logic rd, input logic [4:0] phy_a, input logic [4:0] reg_a,
             input logic [15:0] wd);
    logic [17:0] hdr;
    logic s;
    logic [15:0] rd_v;
    hdr = {4'hF, 2'b01, rd ? 2'b10 : 2'b01, phy_a, reg_a};
    rd_v = 16'h0;
    wr_n = 0;
    rq_n = 0;
    for (int i = 17; i >= 0; i--) mbit(hdr[i], s);
    for (int j = 0; j < 18; j++) begin
      mbit(j < 2 ? (j == 0) : wd[17 - j], s);
      if (j >= 2) rd_v = {rd_v[14:0], s};
    end
    if (rd) chk(rd_v, 16'hC3A5);
    else chk(mgmt_word.data, wd);
    chk(16'(mgmt_word.regad), 16'(reg_a));
    chk(16'(mgmt_word.phy), 16'(phy_a));
    chk(16'(wr_n * 16 + rq_n), rd ? 16'h0001 : 16'h0010);
  endtask : mxfer
  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // main sequence: idle port, serial variant, phy role, mac role
  initial begin
    // reset low from time zero, straps at their pulled defaults
    {rst_n, flow_s, role_s, ext_s, sni_s} = 5'h08;
    {sw_out_valid, sw_half_duplex, sw_collision, col_drv, mclk} = 5'h00;
    sw_out_nibble = 4'h0;
    mdio_drv = 1'b1;
    strap(1'b1, 1'b0, 1'b0, 1'b0);
    push(32);
    chk(16'(sw_out_ready), 16'h0000);
    chk(16'(ext_port_tx_clock_oe), 16'h0000);
    strap(1'b0, 1'b0, 1'b1, 1'b1);
    chk(16'(ext_port_tx_clock_oe), 16'h0000);
    strap(1'b0, 1'b0, 1'b1, 1'b0);
    chk(16'(ext_port_tx_clock_oe), 16'h0001);
    chk(16'(ext_port_rx_clock_oe), 16'h0000);
    egress(12);
    ingress(6);
    {sw_half_duplex, sw_collision} = 2'b11;
    repeat (4) @(negedge clock);
    chk(16'(ext_port_collision_o), 16'h0001);
    sw_half_duplex = 1'b0;
    repeat (4) @(negedge clock);
    chk(16'(ext_port_collision_o), 16'h0000);
    sw_collision = 1'b0;
    mxfer(1'b1, 5'h03, 5'h11, 16'hFFFF);
    mxfer(1'b0, 5'h1C, 5'h06, 16'h5A3C);
    strap(1'b1, 1'b1, 1'b1, 1'b0);
    chk(16'(ext_port_tx_nibble_oe), 16'h0001);
    egress(40);
    ingress(6);
    col_drv = 1'b1;
    repeat (8) @(negedge clock);
    chk(16'(sw_partner_collision), 16'h0001);
    col_drv = 1'b0;
    repeat (8) @(negedge clock);
    chk(16'(sw_partner_collision), 16'h0000);
    final_report();
  end
endmodule : tb_top
